// *** hdl/pdg_pkg.sv ***
// pdg_pkg: constants, register map and state carrier for the pwm generator
// assumes a single 200 MHz clock domain and the plain register port
package pdg_pkg;

   // ==========================================================
   // register map (word offsets on the plain register port)
   localparam logic [2:0] PDG_OFF_CTRL     = 3'h0; // channel control
   localparam logic [2:0] PDG_OFF_PERIOD   = 3'h1; // period limit
   localparam logic [2:0] PDG_OFF_DUTY_HI  = 3'h2; // duty bits 9..2
   localparam logic [2:0] PDG_OFF_TCON     = 3'h3; // timer config
   localparam logic [2:0] PDG_OFF_TIMER    = 3'h4; // period timer (rw)
   localparam logic [2:0] PDG_OFF_SHADOW   = 3'h5; // duty shadow bits 9..2
   localparam logic [2:0] PDG_OFF_STATUS   = 3'h6; // status (ro)

   // ==========================================================
   // field positions
   localparam int PDG_CTRL_DLO_LSB  = 4;   // ctrl[5:4] duty bits 1..0
   localparam int PDG_CTRL_MODE_LSB = 0;   // ctrl[3:0] mode
   localparam logic [3:0] PDG_MODE_PWM = 4'hC; // pwm when mode[3:2]=11
   localparam int PDG_TCON_PRE_LSB  = 0;   // tcon[1:0] prescale select
   localparam int PDG_TCON_ON_BIT   = 2;   // tcon[2] timer on
   localparam int PDG_TCON_POST_LSB = 3;   // tcon[6:3] postscale - 1

   // ==========================================================
   // reset values
   localparam logic [7:0] PDG_RST_PERIOD = 8'hFF;
   localparam logic [7:0] PDG_RST_ZERO8  = 8'h00;
   localparam logic [9:0] PDG_RST_ZERO10 = 10'h000;

   // ==========================================================
   // timing: one instruction tick is four oscillator periods
   localparam int PDG_OSC_PER_TICK = 4;

   typedef enum logic [1:0]
   {
      PDG_IDLE = 2'b00,
      PDG_RUN  = 2'b01
   } pdg_state_type;

   typedef struct packed
   {
      pdg_state_type state;
      logic [7:0]    ctrl;
      logic [7:0]    period;
      logic [7:0]    duty_hi;
      logic [6:0]    tcon;
      logic [7:0]    timer;
      logic [3:0]    presc;     // oscillator + prescaler count
      logic [3:0]    postc;
      logic [9:0]    shadow;
      logic          pin;
      logic          post_evt;
      logic [7:0]    rdata;
   } pdg_regs_type;

   typedef struct packed
   {
      logic [2:0] addr;
      logic [7:0] wdata;
      logic       wr;
      logic       rd;
   } pdg_bus_type;

endpackage

// *** hdl/pdg_top.sv ***
// pdg_top: single-channel pwm generator with period timer and prescaler
// assumes i_mclk is the oscillator clock; software drives the port
// Function
// - pin carries a pwm waveform with ten-bit duty resolution
// - writing zero to channel control forces channel output latch low
// - period is (limit+1) times four oscillator periods times prescale
// - timer matching limit clears to zero at next increment
// - pin set at each restart in pwm mode unless duty is zero
// - duty value copied to shadow at each period restart
// - postscaler divides match events only, never the period
// - cycle is one period long, with high time from the duty value
//
// Decided for this implementation: the plain strobed port and the address map.
`timescale 1ns/10ps
module pdg_top
(
   input  wire logic              i_mclk,
   input  wire logic              i_reset_n,
   input  wire pdg_pkg::pdg_bus_type i_bus,
   input  wire logic              i_pin_dir_out,
   output logic [7:0]             o_rdata,
   output logic                   o_pin_out,
   output logic                   o_pin_oe,
   output logic                   o_post_event
);
   import pdg_pkg::*;

   pdg_regs_type r_reg;
   pdg_regs_type r_next;
   logic [3:0]   pre_max;
   logic         tick;
   logic         pwm_en;
   logic [9:0]   duty_new;
   logic [9:0]   timer_ext;
   logic         restart;
   logic [1:0]   sub_count;

   // ==========================================================
   // prescale: 4 oscillator periods per tick times 1 or 4
   // every select other than 00 gives 16 clocks per tick, so a x16
   // setting runs at x4; software that needs x16 must use a longer limit
   always_comb
   begin
      case (r_reg.tcon[PDG_TCON_PRE_LSB +: 2])
         2'b00:   pre_max = 4'(PDG_OSC_PER_TICK - 1);
         2'b01:   pre_max = 4'hF;
         default: pre_max = 4'hF;
      endcase
   end

   // ==========================================================
   // next-state logic
   // one pass builds the whole next state: prescaler, timer, shadow,
   // pin latch, postscaler and the register port, in that order, so
   // a software write in the same cycle overrides the timer count
   always_comb
   begin
      r_next   = r_reg;
      tick     = 1'b0;
      pwm_en   = (r_reg.ctrl[3:2] == PDG_MODE_PWM[3:2]);
      duty_new = {r_reg.duty_hi, r_reg.ctrl[PDG_CTRL_DLO_LSB +: 2]};
      r_next.post_evt = 1'b0;
      // prescale counter
      // presc counts oscillator clocks; a tick moves the period timer
      // once per four clocks (x1) or once per sixteen (x4)
      case (r_reg.state)
         PDG_IDLE:
         begin
            if (r_reg.tcon[PDG_TCON_ON_BIT])
            begin
               r_next.state = PDG_RUN;
            end
         end
         PDG_RUN:
         begin
            if (!r_reg.tcon[PDG_TCON_ON_BIT])
            begin
               r_next.state = PDG_IDLE;
            end
            else if (r_reg.presc == pre_max)
            begin
               r_next.presc = 4'h0;
               tick = 1'b1;
            end
            else
            begin
               r_next.presc = r_reg.presc + 4'h1;
            end
         end
         default:
         begin
            r_next.state = PDG_IDLE;
         end
      endcase
      // period boundary
      // a restart is the tick on which the timer sits on the limit
      restart = tick && (r_reg.timer == r_reg.period);
      if (tick)
      begin
         if (r_reg.timer == r_reg.period)
         begin
            r_next.timer  = PDG_RST_ZERO8;
            r_next.shadow = duty_new;
            r_next.pin    = pwm_en && (duty_new != PDG_RST_ZERO10);
            if (r_reg.postc == r_reg.tcon[PDG_TCON_POST_LSB +: 4])
            begin
               r_next.postc    = 4'h0;
               r_next.post_evt = 1'b1;
            end
            else
            begin
               r_next.postc = r_reg.postc + 4'h1;
            end
         end
         else
         begin
            r_next.timer = r_reg.timer + 8'h01;
         end
      end
      // ten-bit compare
      // the duty count is the timer with two sub-tick bits below it:
      // single clocks at x1, groups of four clocks at x4, so one duty
      // step lasts one oscillator period times the prescale. the
      // compare looks at the count the next cycle will hold, so the
      // registered pin falls on the clock at which the count reaches
      // the duty value and the high time is exactly duty steps long;
      // the present count would stretch every pulse by one clock.
      // a duty value beyond the count range keeps the pin high all period
      if (r_reg.tcon[PDG_TCON_PRE_LSB +: 2] == 2'b00)
      begin
         sub_count = r_next.presc[1:0];
      end
      else
      begin
         sub_count = r_next.presc[3:2];
      end
      timer_ext = {r_next.timer, sub_count};
      // set beats clear
      // a restart that sets the pin wins over a same-cycle match
      if (r_reg.state == PDG_RUN && timer_ext == r_next.shadow
          && !restart)
      begin
         r_next.pin = 1'b0;
      end
      if (!pwm_en)
      begin
         r_next.pin = 1'b0;
      end
      // register writes
      if (i_bus.wr)
      begin
         case (i_bus.addr)
            PDG_OFF_CTRL:
            begin
               r_next.ctrl = i_bus.wdata;
               if (i_bus.wdata == PDG_RST_ZERO8)
               begin
                  r_next.pin = 1'b0;
               end
            end
            PDG_OFF_PERIOD:  r_next.period  = i_bus.wdata;
            PDG_OFF_DUTY_HI: r_next.duty_hi = i_bus.wdata;
            PDG_OFF_TCON:    r_next.tcon    = i_bus.wdata[6:0];
            PDG_OFF_TIMER:   r_next.timer   = i_bus.wdata;
            default:         r_next.tcon    = r_reg.tcon;
         endcase
      end
      // register reads, data valid next cycle
      // unmapped offsets read zero, and the data falls back to zero
      // after one cycle so a stale word is never taken twice
      r_next.rdata = PDG_RST_ZERO8;
      if (i_bus.rd)
      begin
         case (i_bus.addr)
            PDG_OFF_CTRL:    r_next.rdata = r_reg.ctrl;
            PDG_OFF_PERIOD:  r_next.rdata = r_reg.period;
            PDG_OFF_DUTY_HI: r_next.rdata = r_reg.duty_hi;
            PDG_OFF_TCON:    r_next.rdata = {1'b0, r_reg.tcon};
            PDG_OFF_TIMER:   r_next.rdata = r_reg.timer;
            PDG_OFF_SHADOW:  r_next.rdata = r_reg.shadow[9:2];
            PDG_OFF_STATUS:  r_next.rdata = {5'h00, r_reg.shadow[1:0],
                                             r_reg.pin};
            default:         r_next.rdata = PDG_RST_ZERO8;
         endcase
      end
   end

   // ==========================================================
   // state register
   // reset loads constants only; the limit starts at all ones so an
   // unconfigured timer gives the longest period, never a short one
   always_ff @(posedge i_mclk or negedge i_reset_n)
   begin
      if (!i_reset_n)
      begin
         r_reg        <= '0;
         r_reg.state  <= PDG_IDLE;
         r_reg.period <= PDG_RST_PERIOD;
      end
      else
      begin
         r_reg <= r_next;
      end
   end

   // ==========================================================
   // outputs; the pad drives only when software set direction out
   // the pin comes straight from a flip-flop, so the pad never sees a
   // glitch while the count passes the duty value
   // direction gates drive
   assign o_pin_oe     = i_pin_dir_out;
   assign o_pin_out    = r_reg.pin;
   assign o_rdata      = r_reg.rdata;
   assign o_post_event = r_reg.post_evt;

endmodule

// *** tb/pdg_load.sv ***
// pdg_load: load on the modulator pin, times high time and period
// assumes one clock; a pull-down holds an undriven pin low
`timescale 1ns/10ps
module pdg_load
(
   input  wire logic        i_mclk,
   input  wire logic        i_pin_out,
   input  wire logic        i_pin_oe,
   output logic      [15:0] o_hi,
   output logic      [15:0] o_per
);
   logic [15:0] cnt_reg = 16'h0000;
   logic        lvl_reg = 1'b0;
   logic        lvl;
   assign lvl = i_pin_oe & i_pin_out;
   // period from rise to rise, high time taken at the fall
   always_ff @(posedge i_mclk)
   begin
      lvl_reg <= lvl;
      cnt_reg <= (lvl & ~lvl_reg) ? 16'h0001 : cnt_reg + 16'h0001;
      if (lvl & ~lvl_reg)
         o_per <= cnt_reg;
      if (~lvl & lvl_reg)
         o_hi <= cnt_reg;
   end
endmodule

// *** tb/pdg_monitor.sv ***
// pdg_monitor: port assertions for the pwm generator
// assumes it is bound to pdg_top
`timescale 1ns/10ps
module pdg_monitor
(
   input wire logic                 i_mclk,
   input wire logic                 i_reset_n,
   input wire pdg_pkg::pdg_bus_type i_bus,
   input wire logic                 i_pin_dir_out,
   input wire logic           [7:0] o_rdata,
   input wire logic                 o_pin_out,
   input wire logic                 o_pin_oe,
   input wire logic                 o_post_event
);
   import pdg_pkg::*;
   default clocking cb @(posedge i_mclk); endclocking
   default disable iff (!i_reset_n);
   property p_oe; o_pin_oe == i_pin_dir_out; endproperty
   a_oe: assert property (p_oe)
      else $error("enable differs");
   property p_rd0; !$past(i_bus.rd) |-> o_rdata == 8'h00; endproperty
   a_rd0: assert property (p_rd0)
      else $error("read data not idle");
   property p_unm; i_bus.rd && i_bus.addr == 3'h7 |=> o_rdata == 8'h00;
   endproperty
   a_unm: assert property (p_unm)
      else $error("unmapped read");
   property p_clr; i_bus.wr && i_bus.addr == PDG_OFF_CTRL &&
      i_bus.wdata == 8'h00 |-> ##2 !o_pin_out [*2]; endproperty
   a_clr: assert property (p_clr)
      else $error("pin not cleared");
   property p_post; o_post_event |=> !o_post_event; endproperty
   a_post: assert property (p_post)
      else $error("post pulse long");
   property p_sts; i_bus.rd && i_bus.addr == PDG_OFF_STATUS |=>
      o_rdata[0] == $past(o_pin_out) && o_rdata[7:3] == 5'h00; endproperty
   a_sts: assert property (p_sts)
      else $error("status pin");
   property p_per; i_bus.wr && i_bus.addr == PDG_OFF_PERIOD ##1 i_bus.rd
      && i_bus.addr == PDG_OFF_PERIOD |=> o_rdata == $past(i_bus.wdata, 2);
   endproperty
   a_per: assert property (p_per)
      else $error("period readback");
   property p_dut; i_bus.wr && i_bus.addr == PDG_OFF_DUTY_HI ##1 i_bus.rd
      && i_bus.addr == PDG_OFF_DUTY_HI |=> o_rdata == $past(i_bus.wdata, 2);
   endproperty
   a_dut: assert property (p_dut)
      else $error("duty readback");
endmodule

// *** tb/testbench.sv ***
// testbench: random pwm setups measured by the pin load
// assumes pdg_pkg, pdg_top, pdg_load and pdg_monitor compiled first
`timescale 1ns/10ps
module testbench;
   import pdg_pkg::*;
   logic        i_mclk = 1'b0;
   logic        i_reset_n;
   logic        dir_r;
   logic        pin;
   logic        oe;
   logic [7:0]  rdata;
   logic [15:0] hi;
   logic [15:0] per_cnt;
   logic [15:0] rv;
   logic [15:0] scale;
   logic [9:0]  duty;
   logic [7:0]  per;
   pdg_bus_type bus_r;
   integer      seed = 16;
   integer      error_cnt = 0;
   integer      total_checks = 0;
   // ==========================================================
   // clock, design and load
   always #2.5 i_mclk = ~i_mclk;
   pdg_top i_dut (.i_mclk(i_mclk), .i_reset_n(i_reset_n), .i_bus(bus_r),
      .i_pin_dir_out(dir_r), .o_rdata(rdata), .o_pin_out(pin),
      .o_pin_oe(oe), .o_post_event());
   pdg_load i_load (.i_mclk(i_mclk), .i_pin_out(pin), .i_pin_oe(oe),
      .o_hi(hi), .o_per(per_cnt));
   // clocks per period: limit+1 ticks of four, times prescale
   function automatic logic [15:0] exp_per(logic [7:0] p, logic x4);
      return 16'((p + 1) * PDG_OSC_PER_TICK * (x4 ? 4 : 1));
   endfunction
   // clocks of high time: one duty step is one clock, four at x4
   function automatic logic [15:0] exp_hi(logic [9:0] d, logic x4);
      return 16'(d * (x4 ? 4 : 1));
   endfunction
   // one bus cycle; strobes stay until the next call replaces them
   task automatic bus(logic [2:0] a, logic [7:0] d, logic w, logic r);
      bus_r <= {a, d, w, r};
      @(posedge i_mclk);
      #1;
      rv = {8'h00, rdata};
   endtask
   task automatic chk(string n, logic [15:0] e, logic [15:0] s);
      total_checks++;
      if (s !== e)
      begin
         error_cnt++;
         $display("wrong value %s expected %h seen %h", n, e, s);
      end
   endtask
   task automatic print_verdict;
      $display("checks %0d errors %0d", total_checks, error_cnt);
      if (error_cnt == 0 && total_checks > 0)
         $display("ALL CHECKS OK");
      else
         $display("CHECKS NOT OK");
      $finish;
   endtask
   // main sequence
   initial
   begin
      i_reset_n = 1'b0;
      bus_r = '0;
      dir_r = 1'b0;
      repeat (10) @(posedge i_mclk);
      i_reset_n <= 1'b1;
      @(posedge i_mclk);
      #1;
      bus(PDG_OFF_PERIOD, 8'h00, 1'b0, 1'b1);
      chk("period reset", 16'h00FF, rv);
      bus(3'h7, 8'h5A, 1'b1, 1'b0);
      bus(3'h7, 8'h00, 1'b0, 1'b1);
      chk("unmapped", 16'h0000, rv);
      dir_r <= 1'b1;
      for (int k = 0; k < 4; k++)
      begin
         per = 8'({$random(seed)} % 6 + 1);
         duty = (k == 3) ? 10'h000 : 10'({$random(seed)} % (4 * per) + 1);
         scale = exp_per(per, k[0]);
         bus(PDG_OFF_DUTY_HI, duty[9:2], 1'b1, 1'b0);
         bus(PDG_OFF_DUTY_HI, 8'h00, 1'b0, 1'b1);
         chk("duty byte", {8'h00, duty[9:2]}, rv);
         bus(PDG_OFF_CTRL, {2'b00, duty[1:0], PDG_MODE_PWM}, 1'b1, 1'b0);
         bus(PDG_OFF_PERIOD, per, 1'b1, 1'b0);
         bus(PDG_OFF_PERIOD, 8'h00, 1'b0, 1'b1);
         bus(PDG_OFF_TIMER, 8'h00, 1'b1, 1'b0);
         bus(PDG_OFF_TCON, {1'b0, 4'($random(seed)), 2'b10, k[0]}, 1'b1,
            1'b0);
         bus(3'h0, 8'h00, 1'b0, 1'b0);
         repeat (12 * scale) @(posedge i_mclk);
         #1;
         bus(PDG_OFF_STATUS, 8'h00, 1'b0, 1'b1);
         if (duty == 10'h000)
            chk("zero duty pin", 16'h0000, {15'h0000, rv[0]});
         else
            chk("period clocks", scale, per_cnt);
         chk("shadow low", 16'(duty[1:0]), 16'(rv[2:1]));
         bus(PDG_OFF_SHADOW, 8'h00, 1'b0, 1'b1);
         chk("shadow high", 16'(duty[9:2]), rv);
         if (duty != 10'h000)
            chk("high clocks", exp_hi(duty, k[0]), hi);
         if (k == 2)
         begin
            // clear while the pulse is high so the latch really drops
            bus(3'h0, 8'h00, 1'b0, 1'b0);
            while (pin !== 1'b1)
            begin
               @(posedge i_mclk);
               #1;
            end
            bus(PDG_OFF_CTRL, 8'h00, 1'b1, 1'b0);
            chk("pin after clear", 16'h0000, {15'h0000, pin});
            bus(3'h0, 8'h00, 1'b0, 1'b0);
            repeat (scale) @(posedge i_mclk);
            #1;
            chk("cleared pin", 16'h0000, {15'h0000, pin});
         end
      end
      bus(3'h0, 8'h00, 1'b0, 1'b0);
      print_verdict();
   end
   // watchdog well beyond the longest run
   initial
   begin
      #200000;
      error_cnt++;
      print_verdict();
   end
endmodule
bind pdg_top pdg_monitor i_mon (.i_mclk(i_mclk), .i_reset_n(i_reset_n),
   .i_bus(i_bus), .i_pin_dir_out(i_pin_dir_out), .o_rdata(o_rdata),
   .o_pin_out(o_pin_out), .o_pin_oe(o_pin_oe), .o_post_event(o_post_event));
